/* design/audio_codec_dma_host_port.v */
// audio codec host port: pin-level 8-bit register access, playback and
// capture dma handshakes, sample counter interrupt, calibration and init.
// assumes host bus pins arrive asynchronous to clk_sys and that adc/dac
// samples are exchanged on clk_sys at the sample tick.
`timescale 1ns/1ps
`default_nettype none
`include "codec_port_consts.vh"

module audio_codec_dma_host_port #(
    parameter SAMPLE_DIV = `SAMPLE_DIV,
    parameter INIT_CYCLES = `INIT_CYCLES
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // host bus pins
    input wire [1:0] bus_addr,
    input wire bus_cs_n,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire [7:0] bus_data_in,
    output reg [7:0] bus_data_out,
    output wire bus_data_oe,
    // dma handshake pins
    output wire playback_request,
    input wire playback_ack_n,
    output wire capture_request,
    input wire capture_ack_n,
    // interrupt, buffer control, power down
    output wire irq,
    output reg ext_buffer_enable,
    output reg ext_buffer_direction,
    input wire power_down_n,
    // converter side
    input wire [15:0] adc_left,
    input wire [15:0] adc_right,
    output reg [15:0] dac_left,
    output reg [15:0] dac_right
);

    // two-flop synchronisers for the bus, dma and power down pins; s1_ff is not read by logic
    reg [15:0] s1_ff;
    reg [15:0] s2_ff;
    reg [2:0] prev_ff;
    wire [15:0] pin_raw = {power_down_n, capture_ack_n, playback_ack_n, bus_cs_n,
                           bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
    always @(posedge clk_sys)
    begin
        s1_ff <= pin_raw;
        s2_ff <= s1_ff;
        prev_ff <= {s2_ff[15], s2_ff[11], s2_ff[10]};
    end

    wire s_pdn = s2_ff[15];
    wire ack_cp = ~s2_ff[14];
    wire ack_pb = ~s2_ff[13];
    wire sel = ~s2_ff[12];
    wire rd_act = ~s2_ff[11];
    wire wr_act = ~s2_ff[10];
    wire [1:0] s_addr = s2_ff[9:8];
    wire [7:0] s_din = s2_ff[7:0];
    wire rd_fall = rd_act & prev_ff[1];
    wire rd_rise = ~rd_act & ~prev_ff[1];
    wire wr_fall = wr_act & prev_ff[0];
    wire wr_rise = ~wr_act & ~prev_ff[0];

    // power down holds every flop but the pin synchronisers in reset
    wire lrst = ~rst_n | ~s_pdn;

    // registers
    reg [7:0] idx_ff;
    reg [7:0] fmt_ff;
    reg [7:0] cfg_ff;
    reg [7:0] pin_ff;
    reg [7:0] loop_ff;
    reg [7:0] base_hi_ff;
    reg [7:0] base_lo_ff;
    reg irq_flag_ff;
    reg [15:0] cur_cnt_ff;
    reg [15:0] init_cnt_ff;
    reg [7:0] cal_cnt_ff;
    reg [15:0] div_ff;
    reg pen_eff_ff;
    reg cen_eff_ff;

    wire init_busy = (init_cnt_ff != 16'h0000);
    wire cal_busy = (cal_cnt_ff != 8'h00);
    wire mode_change_enable = idx_ff[`IDX_MCE];
    wire single_channel_dma = cfg_ff[`CFG_SDC];
    wire tick = (div_ff == 16'h0000);

    // bytes per sample for the current format
    wire wide = fmt_ff[`FMT_WIDE];
    wire stereo = fmt_ff[`FMT_STEREO];
    wire [1:0] last_byte = (wide & stereo) ? 2'h3 : ((wide | stereo) ? 2'h1 : 2'h0);

    // playback and capture dma state
    reg pb_req_ff;
    reg pb_mid_ff;
    reg pb_full_ff;
    reg [1:0] pb_cnt_ff;
    reg [31:0] pb_buf_ff;
    reg [31:0] play_ff;
    reg cp_req_ff;
    reg cp_mid_ff;
    reg cp_full_ff;
    reg [1:0] cp_cnt_ff;
    reg [31:0] cp_buf_ff;

    wire pb_idle = ~pb_req_ff & ~pb_mid_ff & (pb_cnt_ff == 2'h0);
    wire cp_idle = ~cp_req_ff & ~cp_mid_ff & (cp_cnt_ff == 2'h0);
    // single channel with both enabled favours playback
    wire cp_on = cen_eff_ff & ~(single_channel_dma & pen_eff_ff);
    wire cp_busy = ~cp_idle;

    // acks mark dma cycles; capture ack ignored in single channel
    wire dma_mode = ack_pb | (~single_channel_dma & ack_cp);
    // register access needs select with both acks inactive
    wire pio = sel & ~ack_pb & ~ack_cp;
    // single channel hands the playback ack to a pending capture
    wire pb_sel = ack_pb & ~(single_channel_dma & cp_busy);
    wire cp_sel = single_channel_dma ? (ack_pb & cp_busy) : ack_cp;

    // dual mode keeps both pins independent
    // capture pin held low in single channel
    assign capture_request = ~single_channel_dma & cp_req_ff;
    assign playback_request = pb_req_ff | (single_channel_dma & cp_req_ff);
    // irq pin gated by the enable bit
    assign irq = pin_ff[`PIN_IEN] & irq_flag_ff;
    assign bus_data_oe = rd_act & (pio | cp_sel);

    // sample to/from byte buffer, little endian, left first
    function [31:0] pack;
        input [15:0] l;
        input [15:0] r;
        input w;
        input st;
        begin
            case ({w, st})
                2'b11: pack = {r, l};
                2'b10: pack = {16'h0000, l};
                2'b01: pack = {16'h0000, r[15:8] ^ 8'h80, l[15:8] ^ 8'h80};
                default: pack = {24'h000000, l[15:8] ^ 8'h80};
            endcase
        end
    endfunction

    // returns {right, left} as signed 16-bit
    function [31:0] unpack;
        input [31:0] b;
        input w;
        input st;
        begin
            case ({w, st})
                2'b11: unpack = b;
                2'b10: unpack = {b[15:0], b[15:0]};
                2'b01: unpack = {b[15:8] ^ 8'h80, 8'h00, b[7:0] ^ 8'h80, 8'h00};
                default: unpack = {b[7:0] ^ 8'h80, 8'h00, b[7:0] ^ 8'h80, 8'h00};
            endcase
        end
    endfunction

    // sample clock divider and init counter
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            div_ff <= 16'h0000;
            init_cnt_ff <= INIT_CYCLES[15:0];
        end
        else
        begin
            div_ff <= tick ? (SAMPLE_DIV[15:0] - 16'h0001) : (div_ff - 16'h0001);
            if (init_busy)
                init_cnt_ff <= init_cnt_ff - 16'h0001;
        end
    end

    // register writes on the rising write strobe, latched from synced data
    wire reg_wr = pio & wr_rise & ~init_busy;
    wire [3:0] ia = idx_ff[3:0];
    wire wr_idata = reg_wr & (s_addr == `A_IDATA);
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            idx_ff <= `IDX_RST;
            fmt_ff <= `REG_RST;
            cfg_ff <= `CFG_RST;
            pin_ff <= `REG_RST;
            loop_ff <= `REG_RST;
            base_hi_ff <= `REG_RST;
            base_lo_ff <= `REG_RST;
        end
        else
        begin
            if (reg_wr & (s_addr == `A_INDEX))
                idx_ff <= {1'b0, s_din[6:0]};
            if (wr_idata)
            begin
                case (ia)
                    // format changes need mode change enable
                    `IX_FMT: if (mode_change_enable) fmt_ff <= s_din;
                    // enables writable any time; rest needs mce
                    `IX_CFG: cfg_ff <= mode_change_enable ? s_din : {cfg_ff[7:2], s_din[1:0]};
                    `IX_PIN: pin_ff <= s_din;
                    `IX_LOOP: loop_ff <= s_din;
                    `IX_CNT_HI: base_hi_ff <= s_din;
                    `IX_CNT_LO: base_lo_ff <= s_din;
                    default: ;
                endcase
            end
        end
    end

    // calibration after mode change enable falls with the calibrate bit
    wire mce_fall = reg_wr & (s_addr == `A_INDEX) & mode_change_enable & ~s_din[`IDX_MCE];
    always @(posedge clk_sys)
    begin
        if (lrst)
            cal_cnt_ff <= 8'h00;
        else if (mce_fall & cfg_ff[`CFG_CALIBRATE_ON_EXIT])
            cal_cnt_ff <= `CAL_SAMPLES + 8'h01;
        else if (cal_busy & tick)
            cal_cnt_ff <= cal_cnt_ff - 8'h01;
    end

    // enables take effect only once the direction is idle
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            pen_eff_ff <= 1'b0;
            cen_eff_ff <= 1'b0;
        end
        else
        begin
            if (pb_idle)
                pen_eff_ff <= cfg_ff[`CFG_PEN];
            if (cp_idle)
                cen_eff_ff <= cfg_ff[`CFG_CEN];
        end
    end

    // sample counter and interrupt flag; a rollover beats a status write
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            cur_cnt_ff <= 16'h0000;
            irq_flag_ff <= 1'b0;
        end
        else
        begin
            // load on upper byte write, count down per sample
            if (wr_idata & (ia == `IX_CNT_HI))
                cur_cnt_ff <= {s_din, base_lo_ff};
            else if (tick & (pen_eff_ff | cp_on))
                cur_cnt_ff <= (cur_cnt_ff == 16'h0000) ? {base_hi_ff, base_lo_ff} : (cur_cnt_ff - 16'h0001);
            // rollover sets flag, any status write clears
            if (tick & (pen_eff_ff | cp_on) & (cur_cnt_ff == 16'h0000))
                irq_flag_ff <= 1'b1;
            else if (reg_wr & (s_addr == `A_STATUS))
                irq_flag_ff <= 1'b0;
        end
    end

    // playback dma path and dac output
    wire pb_last = (pb_cnt_ff == last_byte);
    wire [31:0] play_lr = unpack(play_ff, wide, stereo);
    wire [3:0] att = loop_ff[5:2];
    wire [15:0] lb_l = loop_ff[`LOOP_LBE] ? ($signed(adc_left) >>> att) : 16'h0000;
    wire [15:0] lb_r = loop_ff[`LOOP_LBE] ? ($signed(adc_right) >>> att) : 16'h0000;
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            pb_req_ff <= 1'b0;
            pb_mid_ff <= 1'b0;
            pb_full_ff <= 1'b0;
            pb_cnt_ff <= 2'h0;
            pb_buf_ff <= 32'h00000000;
            play_ff <= 32'h00000000;
            dac_left <= 16'h0000;
            dac_right <= 16'h0000;
        end
        else
        begin
            // ask only when enabled and the buffer is empty
            // once raised it stays until the strobes come
            if (pen_eff_ff & ~pb_full_ff & ~cal_busy & ~init_busy & pb_idle)
                pb_req_ff <= 1'b1;
            // drop on the falling edge of the last strobe
            // held across every byte of the sample
            else if (wr_fall & pb_sel & pb_last)
                pb_req_ff <= 1'b0;
            if (wr_fall & pb_sel)
                pb_mid_ff <= 1'b1;
            else if (wr_rise)
                pb_mid_ff <= 1'b0;
            if (wr_rise & pb_sel & pb_mid_ff)
            begin
                pb_buf_ff[{pb_cnt_ff, 3'b000} +: 8] <= s_din;
                pb_cnt_ff <= pb_last ? 2'h0 : (pb_cnt_ff + 2'h1);
            end
            // underrun keeps play_ff, so the last sample repeats
            if (tick)
            begin
                if (pb_full_ff)
                    play_ff <= pb_buf_ff;
                // loopback summed every sample; wraps on overflow
                dac_left <= play_lr[15:0] + lb_l;
                dac_right <= play_lr[31:16] + lb_r;
            end
            // completion beats consumption so a fresh sample is not lost
            if (wr_rise & pb_sel & pb_mid_ff & pb_last)
                pb_full_ff <= 1'b1;
            else if (tick)
                pb_full_ff <= 1'b0;
        end
    end

    // capture dma path and register read data
    wire cp_last = (cp_cnt_ff == last_byte);
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            cp_req_ff <= 1'b0;
            cp_mid_ff <= 1'b0;
            cp_full_ff <= 1'b0;
            cp_cnt_ff <= 2'h0;
            cp_buf_ff <= 32'h00000000;
            bus_data_out <= 8'h00;
        end
        else
        begin
            // overrun keeps the held sample; never load mid-transfer
            if (tick & cp_on & ~cp_full_ff & cp_idle)
            begin
                cp_buf_ff <= pack(adc_left, adc_right, wide, stereo);
                cp_full_ff <= 1'b1;
            end
            else if (rd_rise & cp_sel & cp_mid_ff & cp_last)
                cp_full_ff <= 1'b0;
            // ask only while enabled with a sample waiting
            if (cp_on & cp_full_ff & ~cal_busy & ~init_busy & cp_idle)
                cp_req_ff <= 1'b1;
            // drop on the falling edge of the last read
            else if (rd_fall & cp_sel & cp_last)
                cp_req_ff <= 1'b0;
            if (rd_fall & cp_sel)
                cp_mid_ff <= 1'b1;
            else if (rd_rise)
                cp_mid_ff <= 1'b0;
            if (rd_rise & cp_sel & cp_mid_ff)
                cp_cnt_ff <= cp_last ? 2'h0 : (cp_cnt_ff + 2'h1);
            if (rd_fall & cp_sel)
                bus_data_out <= cp_buf_ff[{cp_cnt_ff, 3'b000} +: 8];
            // reads during init answer 80 hex
            else if (rd_fall & pio & init_busy)
                bus_data_out <= `INIT_READ;
            else if (rd_fall & pio)
            begin
                case (s_addr)
                    `A_INDEX: bus_data_out <= idx_ff;
                    `A_STATUS: bus_data_out <= {5'h00, cp_full_ff, pb_full_ff, irq_flag_ff};
                    `A_IDATA:
                    begin
                        case (ia)
                            `IX_FMT: bus_data_out <= fmt_ff;
                            `IX_CFG: bus_data_out <= cfg_ff;
                            `IX_PIN: bus_data_out <= pin_ff;
                            `IX_TEST: bus_data_out <= {2'b00, cal_busy, 5'h00};
                            `IX_LOOP: bus_data_out <= loop_ff;
                            `IX_CNT_HI: bus_data_out <= base_hi_ff;
                            `IX_CNT_LO: bus_data_out <= base_lo_ff;
                            default: bus_data_out <= 8'h00;
                        endcase
                    end
                    default: bus_data_out <= 8'h00;
                endcase
            end
        end
    end

    // transceiver control follows each access; direction high on reads
    always @(posedge clk_sys)
    begin
        if (lrst)
        begin
            ext_buffer_enable <= 1'b0;
            ext_buffer_direction <= 1'b0;
        end
        else
        begin
            ext_buffer_enable <= (rd_act | wr_act) & (pio | dma_mode);
            ext_buffer_direction <= rd_act;
        end
    end

endmodule // audio_codec_dma_host_port
`default_nettype wire

/* design/codec_port_consts.vh */
// constants for the codec host port: pin-level register map, field positions,
// reset values and timing counts; definitions only, included by the port module
`ifndef CODEC_PORT_CONSTS_VH
`define CODEC_PORT_CONSTS_VH
// direct register addresses on the two address pins
`define A_INDEX 2'h0
`define A_IDATA 2'h1
`define A_STATUS 2'h2
`define A_PIO 2'h3
// indirect register indices
`define IX_FMT 4'h8
`define IX_CFG 4'h9
`define IX_PIN 4'ha
`define IX_TEST 4'hb
`define IX_LOOP 4'hd
`define IX_CNT_HI 4'he
`define IX_CNT_LO 4'hf
// field positions
`define IDX_INIT 7
`define IDX_MCE 6
`define CFG_PEN 0
`define CFG_CEN 1
`define CFG_SDC 2
`define CFG_CALIBRATE_ON_EXIT 3
`define FMT_STEREO 4
`define FMT_WIDE 6
`define PIN_IEN 1
`define TEST_ACI 5
`define LOOP_LBE 0
// reset values
`define IDX_RST 8'h40
`define CFG_RST 8'h08
`define REG_RST 8'h00
`define INIT_READ 8'h80
// timing
`define CLK_NS 10
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define SAMPLE_DIV 2083
`define CAL_SAMPLES 8'h80
`endif

/* verification/audio_codec_dma_host_port_tb_top.sv */
// testbench for the codec host port: registers, dma, counter, calibration
// and power down through the host model; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module audio_codec_dma_host_port_tb_top;
    // clock, reset, converter inputs and pins
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic power_down_n = 1'b1;
    logic [15:0] adc_left = 16'h2b1a;
    logic [15:0] adc_right = 16'h4d3c;
    wire [1:0] bus_addr;
    wire bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, irq;
    wire [7:0] bus_data_in, bus_data_out;
    wire playback_request, playback_ack_n, capture_request, capture_ack_n;
    wire ext_buffer_enable, ext_buffer_direction;
    wire [15:0] dac_left, dac_right;
    int compares = 0;
    int miscompares = 0;

    // free running clock
    always #5 clk_sys = ~clk_sys;

    // short sample and init counts keep the run brief
    audio_codec_dma_host_port #(.SAMPLE_DIV(20), .INIT_CYCLES(10)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_cs_n(bus_cs_n),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .playback_request(playback_request), .playback_ack_n(playback_ack_n),
        .capture_request(capture_request), .capture_ack_n(capture_ack_n), .irq(irq),
        .ext_buffer_enable(ext_buffer_enable), .ext_buffer_direction(ext_buffer_direction),
        .power_down_n(power_down_n), .adc_left(adc_left), .adc_right(adc_right),
        .dac_left(dac_left), .dac_right(dac_right)
    );
    isa_host_model i_host (
        .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
        .bus_wr_n(bus_wr_n), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .playback_ack_n(playback_ack_n), .capture_ack_n(capture_ack_n),
        .playback_request(playback_request), .capture_request(capture_request)
    );

    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic rq;
        i_host.cyc(1'b0, 2'b00, a, d, q, rq);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        logic rq;
        i_host.cyc(1'b1, 2'b00, a, 8'h00, q, rq);
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(q & m, e);
    endtask

    // one whole sample of four bytes, request must hold until the last
    task automatic xfer(input logic r, input logic [1:0] ak, input logic [31:0] w);
        logic [7:0] q;
        logic rq;
        int i;
        for (i = 0; i < 4; i++)
        begin
            i_host.cyc(r, ak, 2'h0, w[8*i +: 8], q, rq);
            if (r)
                chk(q, w[8*i +: 8]);
            chk(rq, i < 3);
        end
    endtask

    task automatic wait_hi(input logic cap);
        int n;
        for (n = 0; n < 300 && (cap ? capture_request : playback_request) !== 1'b1; n++)
            @(posedge clk_sys);
    endtask

    task automatic t_init;
        rchk(2'h0, 8'hff, 8'h80);
        repeat (20) @(posedge clk_sys);
        rchk(2'h0, 8'hff, 8'h40);
    endtask

    task automatic t_mode;
        logic [7:0] q;
        int n;
        realtime t0;
        wr(2'h0, 8'h48);
        wr(2'h1, 8'h50);
        rchk(2'h1, 8'hff, 8'h50);
        // leave mode change with the calibrate bit at its reset value
        t0 = $realtime;
        wr(2'h0, 8'h0b);
        rchk(2'h1, 8'h20, 8'h20);
        wr(2'h0, 8'h08);
        wr(2'h1, 8'h00);
        rchk(2'h1, 8'hff, 8'h50);
        wr(2'h0, 8'h09);
        wr(2'h1, 8'h01);
        rchk(2'h1, 8'hff, 8'h09);
        repeat (100) @(posedge clk_sys);
        chk(playback_request, 1'b0);
        wr(2'h0, 8'h0b);
        q = 8'hff;
        for (n = 0; n < 400 && q[5] !== 1'b0; n++)
            rd(2'h1, q);
        chk(q & 8'h20, 8'h00);
        // at least 128 periods of 20 cycles, plus poll and sync lag
        chk((($realtime - t0) >= 25600.0) && (($realtime - t0) <= 26400.0), 1'b1);
    endtask

    task automatic t_play;
        wait_hi(1'b0);
        xfer(1'b0, 2'b01, 32'h56781234);
        repeat (60) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(dac_left, 16'h1234);
        chk(dac_right, 16'h5678);
        // nothing more is sent, so the mixer keeps the last sample
        repeat (60) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(dac_left, 16'h1234);
        chk(dac_right, 16'h5678);
        // loopback on, halved converter data is summed into the mixer
        wr(2'h0, 8'h0d);
        wr(2'h1, 8'h05);
        repeat (60) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(dac_left, 16'h27c1);
        chk(dac_right, 16'h7d16);
    endtask

    task automatic t_irq;
        logic [7:0] q;
        int n;
        // six samples programmed as five, low byte first
        wr(2'h0, 8'h0f);
        wr(2'h1, 8'h05);
        wr(2'h0, 8'h0e);
        wr(2'h1, 8'h00);
        q = 8'h00;
        for (n = 0; n < 100 && q[0] !== 1'b1; n++)
            rd(2'h2, q);
        @(negedge clk_sys);
        chk(q[0], 1'b1);
        chk(irq, 1'b0);
        wr(2'h2, 8'h5a);
        rchk(2'h2, 8'h01, 8'h00);
        wr(2'h0, 8'h0a);
        wr(2'h1, 8'h02);
        for (n = 0; n < 300 && irq !== 1'b1; n++)
            @(negedge clk_sys);
        chk(irq, 1'b1);
        chk(n > 40 && n < 120, 1'b1);
    endtask

    task automatic t_cap(input logic single_channel_dma);
        wr(2'h0, 8'h48);
        wr(2'h1, 8'h50);
        wr(2'h0, 8'h49);
        wr(2'h1, {5'h00, single_channel_dma, 2'b10});
        // a pending playback request still gets one whole sample
        if (playback_request === 1'b1)
            xfer(1'b0, 2'b01, 32'h0);
        wr(2'h0, 8'h09);
        wait_hi(!single_channel_dma);
        xfer(1'b1, single_channel_dma ? 2'b01 : 2'b10, 32'h4d3c2b1a);
        if (single_channel_dma)
            chk(capture_request, 1'b0);
    endtask

    task automatic t_pdn;
        @(posedge clk_sys);
        power_down_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        power_down_n <= 1'b1;
        t_init();
        chk(irq, 1'b0);
        t_cap(1'b1);
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_init();
        t_mode();
        t_play();
        t_irq();
        t_cap(1'b0);
        t_pdn();
        results();
    end

    // watchdog: the whole run needs well under 20000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        results();
    end
endmodule // audio_codec_dma_host_port_tb_top
`default_nettype wire

/* verification/codec_port_properties.sv */
// checker for the codec host port pins: request release, data drive,
// buffer control and sample pacing; bound to the port by name
`timescale 1ns/1ps
`default_nettype none
module codec_port_properties #(
    parameter SAMPLE_DIV = 2083
) (
    // clock, reset, power
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_down_n,
    // host strobes and data drive
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic bus_data_oe,
    // dma, irq, buffer, mixer
    input wire logic playback_request,
    input wire logic playback_ack_n,
    input wire logic capture_request,
    input wire logic capture_ack_n,
    input wire logic irq,
    input wire logic ext_buffer_enable,
    input wire logic ext_buffer_direction,
    input wire logic [15:0] dac_left
);
    default clocking dflt @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !power_down_n);

    // cycles since the mixer output last moved, saturating
    reg [15:0] gap_ff;
    always @(posedge clk_sys)
    begin
        if (!rst_n || !power_down_n)
            gap_ff <= 16'hffff;
        else if ($changed(dac_left))
            gap_ff <= 16'h0001;
        else if (gap_ff != 16'hffff)
            gap_ff <= gap_ff + 16'h0001;
    end

    AST_PB_DROP: assert property ($fell(playback_request) |->
        !$past(playback_ack_n, 2) && !$past(bus_rd_n & bus_wr_n, 2))
        else $error("playback request fell without a dma strobe");
    AST_CP_DROP: assert property ($fell(capture_request) |->
        !$past(capture_ack_n, 2) && !$past(bus_rd_n & bus_wr_n, 2))
        else $error("capture request fell without a capture strobe");
    AST_OE: assert property (bus_data_oe |-> !$past(bus_rd_n, 2) || !$past(bus_rd_n, 3))
        else $error("data driven without a read strobe");
    AST_BUF_RD: assert property (!bus_rd_n [*4] |-> ext_buffer_enable && ext_buffer_direction)
        else $error("buffer not set toward host on read");
    AST_BUF_WR: assert property (!bus_wr_n [*4] |-> ext_buffer_enable && !ext_buffer_direction)
        else $error("buffer not set toward port on write");
    AST_BUF_IDLE: assert property ((bus_rd_n && bus_wr_n) [*4] |-> !ext_buffer_enable)
        else $error("buffer enabled with no strobe");
    AST_PDN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !power_down_n [*4] |-> !playback_request && !capture_request && !irq && !ext_buffer_enable)
        else $error("outputs active in power down");
    AST_INIT: assert property ($rose(rst_n) |-> (!playback_request && !capture_request) [*8])
        else $error("request during initialization");
    AST_DAC: assert property ($changed(dac_left) |-> gap_ff >= SAMPLE_DIV - 1)
        else $error("mixer output moved between sample ticks");
endmodule // codec_port_properties

bind audio_codec_dma_host_port codec_port_properties #(.SAMPLE_DIV(SAMPLE_DIV)) i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .power_down_n(power_down_n), .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n), .bus_data_oe(bus_data_oe), .playback_request(playback_request),
    .playback_ack_n(playback_ack_n), .capture_request(capture_request), .capture_ack_n(capture_ack_n),
    .irq(irq), .ext_buffer_enable(ext_buffer_enable), .ext_buffer_direction(ext_buffer_direction),
    .dac_left(dac_left)
);
`default_nettype wire

/* verification/isa_host_model.sv */
// host bus and dma controller model: one task per bus cycle;
// assumes clk_sys paces it and the port never stretches a cycle
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
    // clock
    input wire logic clk_sys,
    // host bus pins
    output logic [1:0] bus_addr = 2'h0,
    output logic bus_cs_n = 1'b1,
    output logic bus_rd_n = 1'b1,
    output logic bus_wr_n = 1'b1,
    output logic [7:0] bus_data_in = 8'h00,
    input wire logic [7:0] bus_data_out,
    // dma handshake
    output logic playback_ack_n = 1'b1,
    output logic capture_ack_n = 1'b1,
    input wire logic playback_request,
    input wire logic capture_request
);
    // one strobe; ak bit0 acks playback, bit1 capture, zero is pio
    task automatic cyc(input logic rd, input logic [1:0] ak, input logic [1:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic rq);
        @(posedge clk_sys);
        bus_cs_n <= ak != 2'b00;
        // dma shows a wrong address, which must not matter
        bus_addr <= (ak != 2'b00) ? ~a : a;
        playback_ack_n <= !ak[0];
        capture_ack_n <= !ak[1];
        bus_data_in <= d;
        @(posedge clk_sys);
        bus_rd_n <= !rd;
        bus_wr_n <= rd;
        // four cycles low so the port's synchronizer sees the strobe
        repeat (4) @(posedge clk_sys);
        q = bus_data_out;
        rq = ak[1] ? capture_request : playback_request;
        bus_rd_n <= 1'b1;
        bus_wr_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // released data flips so a stale byte never passes
        bus_data_in <= ~d;
        bus_cs_n <= 1'b1;
        playback_ack_n <= 1'b1;
        capture_ack_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule // isa_host_model
`default_nettype wire
